/* File: design/dch_pkg.sv */
// Shared constants and types for the driver configuration command handler
package dch_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;
    localparam int FLASH_HALF_MS = 250;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ARG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ANS_HDR = 8'h0c;
    localparam logic [7:0] REG_ANS_VAL = 8'h10;
    localparam logic [7:0] REG_IDENTIFY_FLASH_REM = 8'h14;
    localparam logic [7:0] REG_JOG_VEL = 8'h18;
    localparam logic [7:0] REG_CTRL = 8'h1c;
    localparam logic [7:0] REG_CONF_ID = 8'h20;

    // ------------------------------------------------------------------
    // Field positions, reset values and answer characters
    // ------------------------------------------------------------------
    localparam int CMD_SEL_LSB = 4;
    localparam int CMD_ALL_BIT = 8;
    localparam int CTRL_MOTOR_BIT = 0;
    localparam logic AUX_RST = 1'b1;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [7:0] ASCII_COLON = 8'h3a;
    localparam logic [7:0] ASCII_DOLLAR = 8'h24;
    localparam logic [7:0] ASCII_LBRACE = 8'h7b;
    localparam logic [7:0] ASCII_RBRACE = 8'h7d;

    // ------------------------------------------------------------------
    // Commands, answer codes, parameter kinds
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        DCH_OP_NOP = 4'h0, DCH_OP_AUX_SET = 4'h1, DCH_OP_AUX_QUERY = 4'h2,
        DCH_OP_FLASH_SET = 4'h3, DCH_OP_FLASH_QUERY = 4'h4, DCH_OP_CFG_SET = 4'h5,
        DCH_OP_CFG_DEFAULT = 4'h6, DCH_OP_CFG_EXPERT = 4'h7, DCH_OP_CFG_QUERY = 4'h8,
        DCH_OP_CFG_QUERY_DEF = 4'h9, DCH_OP_EXPERT_QUERY = 4'ha, DCH_OP_TYPE_QUERY = 4'hb,
        DCH_OP_JOG = 4'hc, DCH_OP_CONFIG_ENTER = 4'hd, DCH_OP_CONFIG_LEAVE = 4'he,
        DCH_OP_RSVD = 4'hf
    } dch_op_t;

    typedef enum logic [1:0] {
        DCH_ERR_OK = 2'b00, DCH_ERR_MODE = 2'b01, DCH_ERR_ARG = 2'b10, DCH_ERR_DIR = 2'b11
    } dch_err_t;

    typedef enum logic [1:0] {
        DCH_TY_INT = 2'b00, DCH_TY_FLOAT = 2'b01, DCH_TY_STRING = 2'b10, DCH_TY_LABELS = 2'b11
    } dch_kind_t;

    // ------------------------------------------------------------------
    // Parameter table: slot 0 axis velocity, slot 1 acceleration time in ms
    // ------------------------------------------------------------------
    localparam int MAX_PARAMS = 8;
    localparam int PARAM_VEL_IDX = 0;
    localparam int PARAM_ACC_IDX = 1;
    localparam logic [MAX_PARAMS-1:0][31:0] PARAM_DEFAULT = {
        32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0000,
        32'h0000_0032, 32'h0000_0000, 32'h0000_00fa, 32'h0000_03e8};
    localparam logic [MAX_PARAMS-1:0][1:0] PARAM_KIND = {
        DCH_TY_LABELS, DCH_TY_STRING, DCH_TY_LABELS, DCH_TY_LABELS,
        DCH_TY_INT, DCH_TY_FLOAT, DCH_TY_INT, DCH_TY_INT};
    // String kind: max length; label kind: number of labels
    localparam logic [MAX_PARAMS-1:0][7:0] PARAM_LEN = {
        8'h02, 8'h10, 8'h03, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

endpackage : dch_pkg

/* File: design/dch_handler.sv */
// Driver configuration command handler with a classic Wishbone slave
// Functional notes
// [RQ1] Aux supply off also removes motor power; on re-enables the aux supply.
// [RQ2] Aux supply query answers the current state, on or off.
// [RQ3] Flash request above zero flashes the board that many seconds, then stops.
// [RQ4] Flash request of zero stops any flashing at once.
// [RQ5] Flash query returns remaining time, counting down continuously.
// [RQ6] Parameter writes accepted only in configuration mode; host enters it first.
// [RQ7] Restore-defaults puts every parameter back to its default value.
// [RQ8] Expert marker is set by its command, cleared by any other parameter command; here only set and restore-defaults clear it.
// [RQ9] Expert query answers yes or no; the marker is no parameter.
// [RQ10] Parameter query returns one value, or a delimited list of all.
// [RQ11] Defaults query returns the whole list with default values.
// [RQ12] Type query reports integer, float, bounded string or label set.
// [RQ13] Bounded string type carries its maximum length.
// [RQ14] Label set type is reported enclosed in curly braces.
// [RQ15] Type query without a name returns the type of every parameter.
// [RQ16] Jog runs only in configuration mode, otherwise it is rejected.
// [RQ17] Jog velocity is in steps per second; its sign gives direction.
// [RQ18] A jogging axis ramps to a new velocity instead of stepping.
// [RQ19] Jog acceleration is velocity setting divided by acceleration time.
// [RQ20] A zero jog velocity brings the axis to a stop.
// [RQ21] Validate with non-empty id stores parameters and id, returns to operation.
// [RQ22] Answers echo board address and command ahead of the value.
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module dch_handler #(
    parameter int NUM_PARAMS = dch_pkg::MAX_PARAMS,
    parameter int TICK_CYCLES = dch_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Board identity
    input wire logic [7:0] board_addr_i,
    // Board outputs
    output logic aux_supply_o,
    output logic motor_power_o,
    output logic identify_flash_o,
    output logic config_mode_o,
    output logic nv_store_o,
    output logic [31:0] jog_vel_o
);
    import dch_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int FW = $clog2(FLASH_HALF_MS + 1);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_PARAMS < 2 || NUM_PARAMS > MAX_PARAMS) begin : g_bad_np
        $error("NUM_PARAMS out of range");
    end
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES too small");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [31:0] arg;
        logic aux_on;
        logic motor_req;
        logic motor_on;
        logic [TW-1:0] tick;
        logic [31:0] flash_ms;
        logic [FW-1:0] flash_cnt;
        logic flash;
        logic cfg_mode;
        logic expert;
        logic [NUM_PARAMS-1:0][31:0] params;
        logic [NUM_PARAMS-1:0][31:0] nv;
        logic [31:0] conf_id;
        logic nv_wr;
        dch_op_t op;
        dch_err_t err;
        logic [3:0] idx;
        logic multi;
        logic fin;
        logic [31:0] ans;
        logic signed [31:0] tgt;
        logic signed [31:0] vel;
        logic [31:0] step;
        logic [5:0] div_cnt;
        logic [31:0] rem;
        logic [31:0] quo;
        logic [31:0] dvs;
    } dch_state_t;

    dch_state_t r;
    dch_state_t next_r;

    // Bus access decode, one ack per request
    logic bus_go;
    logic tick_hit;
    assign bus_go = wb_cyc_i && wb_stb_i && !r.ack;
    assign tick_hit = (r.tick == TW'(TICK_CYCLES - 1));

    // Type word: brace, length or label count, brace, kind
    function automatic logic [31:0] type_word(input logic [3:0] i);
        logic lab;
        lab = (PARAM_KIND[i] == DCH_TY_LABELS);
        type_word = {lab ? ASCII_LBRACE : 8'h00, PARAM_LEN[i],              // [RQ13] [RQ14]
                     lab ? ASCII_RBRACE : 8'h00, 6'h00, PARAM_KIND[i]};     // [RQ12]
    endfunction : type_word

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [32:0] rs;
        logic [31:0] q;
        logic [32:0] dif;
        logic [31:0] wm;
        logic [3:0] sel;
        logic [31:0] vabs;
        dch_op_t op;
        rs = '0;
        q = '0;
        dif = '0;
        wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        sel = wb_dat_i[CMD_SEL_LSB +: 4];
        vabs = '0;
        op = dch_op_t'(wb_dat_i[3:0]);
        next_r = r;
        next_r.ack = bus_go;
        next_r.nv_wr = 1'b0;
        next_r.dat = '0;

        // Millisecond tick
        next_r.tick = tick_hit ? '0 : r.tick + TW'(1);

        // Flash countdown and visible toggling
        if (tick_hit && r.flash_ms != 0) begin
            next_r.flash_ms = r.flash_ms - 32'h1;                            // [RQ5]
            if (r.flash_cnt == FW'(FLASH_HALF_MS - 1)) begin
                next_r.flash_cnt = '0;
                next_r.flash = !r.flash;
            end else begin
                next_r.flash_cnt = r.flash_cnt + FW'(1);
            end
        end
        if (r.flash_ms == 0) begin
            next_r.flash = 1'b0;                                             // [RQ3]
        end

        // Serial divider: step per ms = velocity / acceleration time in ms
        if (r.div_cnt != 0) begin
            rs = {r.rem, r.quo[31]};
            q = {r.quo[30:0], 1'b0};
            if (rs >= {1'b0, r.dvs}) begin
                rs = rs - {1'b0, r.dvs};
                q[0] = 1'b1;
            end
            next_r.rem = rs[31:0];
            next_r.quo = q;
            next_r.div_cnt = r.div_cnt - 6'd1;
            if (r.div_cnt == 6'd1) begin
                next_r.step = (q == 0) ? 32'h1 : q;                          // [RQ19]
            end
        end

        // Ramp toward target once per ms, never past it
        if (tick_hit && r.div_cnt == 0 && r.vel != r.tgt) begin
            dif = {r.tgt[31], r.tgt} - {r.vel[31], r.vel};
            if (!dif[32]) begin
                next_r.vel = (dif > {1'b0, r.step}) ? r.vel + $signed(r.step) : r.tgt; // [RQ18]
            end else begin
                next_r.vel = (-dif > {1'b0, r.step}) ? r.vel - $signed(r.step) : r.tgt;
            end
        end

        // Motor power follows request only while aux supply is on
        next_r.motor_on = r.motor_req && r.aux_on;                           // [RQ1]

        // Register access
        if (bus_go && wb_we_i) begin
            if (wb_adr_i == REG_ARG) begin
                next_r.arg = (r.arg & ~wm) | (wb_dat_i & wm);
            end else if (wb_adr_i == REG_CTRL) begin
                if (wb_sel_i[0]) begin
                    next_r.motor_req = wb_dat_i[CTRL_MOTOR_BIT] && r.aux_on;
                end
            end else if (wb_adr_i == REG_CMD && wb_sel_i[0]) begin
                next_r.op = op;                                              // [RQ22]
                next_r.err = DCH_ERR_OK;
                next_r.multi = 1'b0;
                next_r.fin = 1'b0;
                next_r.idx = '0;
                next_r.ans = '0;
                case (op)
                    DCH_OP_AUX_SET: begin
                        next_r.aux_on = (r.arg != 0);
                        if (r.arg == 0) begin
                            next_r.motor_req = 1'b0;                         // [RQ1]
                            next_r.motor_on = 1'b0;
                        end
                    end
                    DCH_OP_AUX_QUERY: next_r.ans = {31'h0, r.aux_on};        // [RQ2]
                    DCH_OP_FLASH_SET: begin
                        next_r.flash_ms = 32'(r.arg * MS_PER_S);             // [RQ3]
                        next_r.flash_cnt = '0;
                        next_r.flash = (r.arg != 0);                         // [RQ4]
                    end
                    DCH_OP_FLASH_QUERY: next_r.ans = r.flash_ms;             // [RQ5]
                    DCH_OP_CFG_SET: begin
                        if (!r.cfg_mode) begin
                            next_r.err = DCH_ERR_MODE;                       // [RQ6]
                        end else if (32'(sel) >= NUM_PARAMS) begin
                            next_r.err = DCH_ERR_ARG;
                        end else begin
                            next_r.params[sel] = r.arg;
                            next_r.expert = 1'b0;                            // [RQ8]
                        end
                    end
                    DCH_OP_CFG_DEFAULT: begin
                        if (!r.cfg_mode) begin
                            next_r.err = DCH_ERR_MODE;                       // [RQ6]
                        end else begin
                            next_r.params = PARAM_DEFAULT[NUM_PARAMS-1:0];   // [RQ7]
                            next_r.expert = 1'b0;                            // [RQ8]
                        end
                    end
                    DCH_OP_CFG_EXPERT: begin
                        if (!r.cfg_mode) begin
                            next_r.err = DCH_ERR_MODE;
                        end else begin
                            next_r.expert = 1'b1;                            // [RQ8]
                        end
                    end
                    DCH_OP_CFG_QUERY, DCH_OP_TYPE_QUERY: begin
                        if (wb_dat_i[CMD_ALL_BIT]) begin
                            next_r.multi = 1'b1;                             // [RQ10] [RQ15]
                        end else if (32'(sel) >= NUM_PARAMS) begin
                            next_r.err = DCH_ERR_ARG;
                        end else begin
                            next_r.ans = (op == DCH_OP_CFG_QUERY) ? r.params[sel]
                                                                  : type_word(sel);
                        end
                    end
                    DCH_OP_CFG_QUERY_DEF: next_r.multi = 1'b1;               // [RQ11]
                    DCH_OP_EXPERT_QUERY: next_r.ans = {31'h0, r.expert};     // [RQ9]
                    DCH_OP_JOG: begin
                        if (!r.cfg_mode) begin
                            next_r.err = DCH_ERR_MODE;                       // [RQ16]
                        end else if (r.vel != 0 && r.arg != 0 && r.arg[31] != r.vel[31]) begin
                            next_r.err = DCH_ERR_DIR;
                        end else begin
                            next_r.tgt = $signed(r.arg);                     // [RQ17] [RQ20]
                            vabs = r.params[PARAM_VEL_IDX][31] ? -r.params[PARAM_VEL_IDX]
                                                              : r.params[PARAM_VEL_IDX];
                            next_r.rem = '0;
                            next_r.quo = vabs;                               // [RQ19]
                            next_r.dvs = (r.params[PARAM_ACC_IDX] == 0) ? 32'h1
                                                                        : r.params[PARAM_ACC_IDX];
                            next_r.div_cnt = 6'd32;
                        end
                    end
                    DCH_OP_CONFIG_ENTER: next_r.cfg_mode = 1'b1;
                    DCH_OP_CONFIG_LEAVE: begin
                        if (!r.cfg_mode) begin
                            next_r.err = DCH_ERR_MODE;
                        end else begin
                            next_r.cfg_mode = 1'b0;
                            next_r.tgt = '0;
                            if (r.arg != 0) begin
                                next_r.nv = r.params;                        // [RQ21]
                                next_r.conf_id = r.arg;
                                next_r.nv_wr = 1'b1;
                            end else begin
                                next_r.params = r.nv;
                            end
                        end
                    end
                    default: next_r.err = DCH_ERR_ARG;
                endcase
            end
        end else if (bus_go) begin
            if (wb_adr_i == REG_ARG) begin
                next_r.dat = r.arg;
            end else if (wb_adr_i == REG_STATUS) begin
                next_r.dat = {24'h0, r.div_cnt != 0, r.vel != 0, r.expert, r.cfg_mode,
                              r.flash_ms != 0, r.motor_on, r.motor_req, r.aux_on};
            end else if (wb_adr_i == REG_ANS_HDR) begin
                next_r.dat = {board_addr_i, r.op, r.idx, r.multi, r.fin, r.err,    // [RQ22]
                              4'h0, r.multi ? ASCII_DOLLAR : ASCII_COLON};
            end else if (wb_adr_i == REG_ANS_VAL) begin
                if (r.multi && !r.fin) begin
                    // Each read pops one list entry; the fin flag in the header marks the end
                    if (r.op == DCH_OP_CFG_QUERY) begin
                        next_r.dat = r.params[r.idx];                        // [RQ10]
                    end else if (r.op == DCH_OP_CFG_QUERY_DEF) begin
                        next_r.dat = PARAM_DEFAULT[r.idx];                   // [RQ11]
                    end else begin
                        next_r.dat = type_word(r.idx);                       // [RQ15]
                    end
                    if (32'(r.idx) == NUM_PARAMS - 1) begin
                        next_r.fin = 1'b1;
                    end else begin
                        next_r.idx = r.idx + 4'h1;
                    end
                end else if (!r.multi) begin
                    next_r.dat = r.ans;
                end
            end else if (wb_adr_i == REG_IDENTIFY_FLASH_REM) begin
                next_r.dat = r.flash_ms;
            end else if (wb_adr_i == REG_JOG_VEL) begin
                next_r.dat = r.vel;
            end else if (wb_adr_i == REG_CTRL) begin
                next_r.dat = {31'h0, r.motor_req};
            end else if (wb_adr_i == REG_CONF_ID) begin
                next_r.dat = r.conf_id;
            end else begin
                next_r.dat = '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.aux_on <= AUX_RST;
            r.step <= 32'h1;
            r.params <= PARAM_DEFAULT[NUM_PARAMS-1:0];
            r.nv <= PARAM_DEFAULT[NUM_PARAMS-1:0];
            r.conf_id <= WORD_RST;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from state flops
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.dat;
    assign aux_supply_o = r.aux_on;
    assign motor_power_o = r.motor_on;
    assign identify_flash_o = r.flash;
    assign config_mode_o = r.cfg_mode;
    assign nv_store_o = r.nv_wr;
    assign jog_vel_o = r.vel;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic cmd_wr;
    assign cmd_wr = bus_go && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i[0];

    sequence s_cmd(logic [3:0] c);
        cmd_wr && wb_dat_i[3:0] == c;
    endsequence

    a_aux_motor_off: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
        !aux_supply_o |-> !motor_power_o) else $error("motor powered with aux off");
    a_aux_answer: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
        s_cmd(DCH_OP_AUX_QUERY) |=> r.ans == {31'h0, aux_supply_o})
        else $error("aux answer mismatch");
    a_flash_start: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
        s_cmd(DCH_OP_FLASH_SET) ##0 (r.arg != 0) |=> r.flash_ms == 32'($past(r.arg) * MS_PER_S)
        ##1 identify_flash_o) else $error("flash did not start");
    a_flash_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
        s_cmd(DCH_OP_FLASH_SET) ##0 (r.arg == 0) |=> !identify_flash_o && r.flash_ms == 0)
        else $error("flash did not stop");
    a_flash_count: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
        tick_hit && r.flash_ms != 0 && !cmd_wr |=> r.flash_ms == $past(r.flash_ms) - 32'h1)
        else $error("flash countdown wrong");
    a_cfg_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        s_cmd(DCH_OP_CFG_SET) ##0 (!r.cfg_mode) |=> r.params == $past(r.params)
        && r.err == DCH_ERR_MODE) else $error("parameter written outside config mode");
    a_default_load: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
        s_cmd(DCH_OP_CFG_DEFAULT) ##0 (r.cfg_mode) |=> r.params == PARAM_DEFAULT[NUM_PARAMS-1:0])
        else $error("defaults not restored");
    a_expert_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
        s_cmd(DCH_OP_CFG_SET) ##0 (r.cfg_mode && 32'(wb_dat_i[7:4]) < NUM_PARAMS) |=> !r.expert)
        else $error("expert marker survived");
    a_jog_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
        s_cmd(DCH_OP_JOG) ##0 (!r.cfg_mode) |=> r.err == DCH_ERR_MODE && r.tgt == $past(r.tgt))
        else $error("jog accepted outside config mode");
    a_jog_ramp: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ18]
        tick_hit && r.div_cnt == 0 && !cmd_wr |=>
        ((r.vel >= $past(r.vel)) ? 32'(r.vel - $past(r.vel)) : 32'($past(r.vel) - r.vel))
        <= $past(r.step)) else $error("jog velocity jumped");
    a_validate_store: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ21]
        s_cmd(DCH_OP_CONFIG_LEAVE) ##0 (r.cfg_mode && r.arg != 0) |=>
        nv_store_o && !config_mode_o && r.nv == $past(r.params) ##1 !nv_store_o)
        else $error("validation did not store");

endmodule : dch_handler

/* File: verification/dch_host.sv */
// Wishbone host model for the handler's register port
`timescale 1ns/1ns
module dch_host (
    // Bus
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o = 1'b0,
    output logic we_o = 1'b0,
    output logic [7:0] adr_o = 8'h00,
    output logic [31:0] dat_o = 32'h0000_0000
);
    int late = 0;
    // Held until ack is sampled or 50 cycles pass; released data is inverted so it never looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        cyc_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        late += (n >= 50);
        q = dat_i;
        cyc_o <= 1'b0;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask : xfer
endmodule : dch_host

/* File: verification/dch_handler_tb.sv */
// Self-checking bench for the command handler
`timescale 1ns/1ns
module dch_handler_tb;
    import dch_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, we, ack, aux, mot, cfg, fl, st;
    logic [7:0] adr;
    logic [31:0] wd, rd, q, jog;
    int bad_count = 0;
    int n_tests = 0, n_store = 0;
    // Short tick keeps ramps and countdowns brief
    dch_handler #(.TICK_CYCLES(10)) i_dch_handler (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .board_addr_i(8'h53),
        .aux_supply_o(aux), .motor_power_o(mot), .identify_flash_o(fl), .config_mode_o(cfg),
        .nv_store_o(st), .jog_vel_o(jog));
    dch_host i_dch_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rd), .cyc_o(cyc), .we_o(we),
        .adr_o(adr), .dat_o(wd));
    // Clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) n_store += (st === 1'b1);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_dch_host.xfer(w, a, d, q);
        if (i_dch_host.late != 0) begin
            close_out();
        end
    endtask : go
    // Argument first, then the command word
    task automatic cmd(input logic [3:0] op, input logic [3:0] ix, input logic [31:0] a);
        go(1'b1, REG_ARG, a);
        go(1'b1, REG_CMD, {24'h0, ix, op});
    endtask : cmd
    task automatic get(input logic [7:0] a);
        go(1'b0, a, 32'h0);
    endtask : get
    task automatic t_aux;
        get(REG_STATUS);
        chk(q[0], AUX_RST);
        go(1'b1, REG_CTRL, 32'h1);
        chk(mot, 1'b1);
        cmd(DCH_OP_AUX_SET, 4'h0, 32'h0);
        chk({aux, mot}, 2'b00);
        cmd(DCH_OP_AUX_QUERY, 4'h0, 32'h0);
        get(REG_ANS_VAL);
        chk(q, 32'h0);
        cmd(DCH_OP_AUX_SET, 4'h0, 32'h1);
        chk(aux, 1'b1);
    endtask : t_aux
    task automatic t_flash;
        cmd(DCH_OP_FLASH_SET, 4'h0, 32'h2);
        chk(fl, 1'b1);
        get(REG_IDENTIFY_FLASH_REM);
        chk(q > 32'd1990 && q <= 32'd2000, 1'b1);
        repeat (30) @(posedge clk_i);
        get(REG_IDENTIFY_FLASH_REM);
        chk(q < 32'd1998, 1'b1);
        cmd(DCH_OP_FLASH_SET, 4'h0, 32'h0);
        chk(fl, 1'b0);
        get(REG_STATUS);
        chk(q[3], 1'b0);
    endtask : t_flash
    task automatic t_cfg;
        cmd(DCH_OP_CFG_SET, 4'h3, 32'h7);
        get(REG_ANS_HDR);
        chk({q[31:24], q[13:12], q[7:0]}, {8'h53, DCH_ERR_MODE, ASCII_COLON});
        cmd(DCH_OP_CONFIG_ENTER, 4'h0, 32'h0);
        cmd(DCH_OP_CFG_SET, 4'h3, 32'h7);
        cmd(DCH_OP_CFG_QUERY, 4'h3, 32'h0);
        get(REG_ANS_VAL);
        chk(q, 32'h7);
        cmd(DCH_OP_CFG_EXPERT, 4'h0, 32'h0);
        cmd(DCH_OP_EXPERT_QUERY, 4'h0, 32'h0);
        get(REG_ANS_VAL);
        chk(q, 32'h1);
        cmd(DCH_OP_CFG_QUERY_DEF, 4'h0, 32'h0);
        for (int i = 0; i < MAX_PARAMS; i++) begin
            get(REG_ANS_VAL);
            chk(q, PARAM_DEFAULT[i]);
        end
        go(1'b1, REG_CMD, 32'h10b);
        for (int i = 0; i < MAX_PARAMS; i++) begin
            get(REG_ANS_VAL);
            chk(q[1:0], PARAM_KIND[i]);
        end
        get(REG_ANS_HDR);
        chk({q[15:14], q[7:0]}, {2'b11, ASCII_DOLLAR});
        cmd(DCH_OP_CFG_DEFAULT, 4'h0, 32'h0);
        cmd(DCH_OP_EXPERT_QUERY, 4'h0, 32'h0);
        get(REG_ANS_VAL);
        chk(q, 32'h0);
        cmd(DCH_OP_CFG_QUERY, 4'h3, 32'h0);
        get(REG_ANS_VAL);
        chk(q, PARAM_DEFAULT[3]);
        cmd(DCH_OP_TYPE_QUERY, 4'h6, 32'h0);
        get(REG_ANS_VAL);
        chk({q[23:16], q[1:0]}, {PARAM_LEN[6], DCH_TY_STRING});
        cmd(DCH_OP_TYPE_QUERY, 4'h7, 32'h0);
        get(REG_ANS_VAL);
        chk({q[31:24], q[15:8]}, {ASCII_LBRACE, ASCII_RBRACE});
    endtask : t_cfg
    // Step is 1000 / 250 = 4 per tick from the default table
    task automatic t_jog;
        cmd(DCH_OP_JOG, 4'h0, 32'd100);
        repeat (60) @(posedge clk_i);
        chk(jog >= 32'd4 && jog <= 32'd16, 1'b1);
        repeat (300) @(posedge clk_i);
        chk(jog, 32'd100);
        cmd(DCH_OP_JOG, 4'h0, -32'sd5);
        get(REG_ANS_HDR);
        chk(q[13:12], DCH_ERR_DIR);
        cmd(DCH_OP_JOG, 4'h0, 32'd0);
        repeat (300) @(posedge clk_i);
        chk(jog, 32'd0);
        cmd(DCH_OP_JOG, 4'h0, -32'sd8);
        repeat (60) @(posedge clk_i);
        chk(jog, -32'sd8);
        cmd(DCH_OP_CONFIG_LEAVE, 4'h0, 32'h1);
        chk(cfg, 1'b0);
        chk(n_store, 32'd1);
        cmd(DCH_OP_JOG, 4'h0, 32'd100);
        get(REG_ANS_HDR);
        chk(q[13:12], DCH_ERR_MODE);
    endtask : t_jog
    task automatic close_out;
        bad_count += i_dch_host.late;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_aux();
        t_flash();
        t_cfg();
        t_jog();
        close_out();
    end
endmodule : dch_handler_tb
